// file: hdl/msp_regs.svh
// register offsets, field positions, reset values and timing counts of the meter setup block
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH
`define MSP_A_CTRL 8'h00
`define MSP_A_CFG 8'h04
`define MSP_A_DATES 8'h08
`define MSP_A_UNIT 8'h0C
`define MSP_A_ADDR 8'h10
`define MSP_A_LIMIT 8'h14
`define MSP_A_OFS 8'h18
`define MSP_A_STAT 8'h1C
`define MSP_CTRL_ENTER 0
`define MSP_CTRL_TRST 1
`define MSP_CTRL_RSTB 2
`define MSP_CTRL_RCMD 4
`define MSP_CFG_OFSEN 4
`define MSP_CFG_HOUREN 5
`define MSP_CFG_WIRED 6
`define MSP_CFG_OUTLET 7
`define MSP_OFS_SIGN 8
`define MSP_STAT_REFUSED 7
`define MSP_TYPE_HC 4'h6
`define MSP_DATE_OFF 16'h0000
`define MSP_DAY_OFF 8'h00
`define MSP_ADDR_MAX 8'hFA
`define MSP_LIMIT_MIN 20'h00200
`define MSP_LIMIT_MAX 20'h18000
`define MSP_LIMIT_OFF 20'h25000
`define MSP_ITEM_FIRST 4'h1
`define MSP_ITEM_HC 4'hB
`define MSP_ITEM_OFS 4'hC
`define MSP_ITEM_RADIO 4'hD
`define MSP_ITEM_LOCK 4'hE
`define MSP_CLK_NS 5
`define MSP_SEC_NS 1000000000
`define MSP_TICK_CYC (`MSP_SEC_NS / `MSP_CLK_NS)
`define MSP_LOCK_S 5
`define MSP_IDLE_MIN 4
`define MSP_IDLE_S (`MSP_IDLE_MIN * 60)
`define MSP_HOUR_S 3600
`endif

// file: hdl/msp_pkg.sv
// types shared by the meter setup block
package msp_pkg;
  typedef enum logic [1:0] {RADIO_PERM_OFF, RADIO_SUSP, RADIO_ON} msp_radio_e;
  typedef struct packed {
    logic [3:0] unit;
    logic [11:0] res;
  } msp_pair_s;
  typedef msp_pair_s [6:0] msp_table_t;
  localparam msp_table_t UNIT_TABLE = {
    {4'h3, 12'h455}, {4'h2, 12'h455}, {4'h3, 12'h407}, {4'h2, 12'h407},
    {4'h4, 12'h419}, {4'h3, 12'h419}, {4'h2, 12'h419}};
  typedef struct packed {
    logic [3:0] item;
    logic [2:0] focus;
    logic editing;
    logic frame;
    logic [2:0] frame_len;
    logic off_ind;
    logic no_radio_ind;
    logic flow_outlet;
    logic [1:0] radio_sym;
  } msp_disp_s;
  typedef struct packed {
    logic flow_outlet;
    msp_pair_s unit_res;
    logic [7:0] bus_addr;
    logic [19:0] heat_cool_limit;
    logic heat_cool_active;
    logic ofs_neg;
    logic [7:0] ofs_dec;
  } msp_cfg_s;
endpackage : msp_pkg

// file: hdl/msp_setup.sv
// meter setup parameter holder: menu key handling, parameter checks, radio state, AHB-Lite registers
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "msp_regs.svh"
module msp_setup #(
  parameter int unsigned TICK_CYC = `MSP_TICK_CYC,
  parameter int unsigned IDLE_S = `MSP_IDLE_S,
  parameter int unsigned HOUR_S = `MSP_HOUR_S,
  parameter msp_pkg::msp_table_t UNIT_TABLE = msp_pkg::UNIT_TABLE
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic key_pin,
  input wire logic first_integ,
  input wire logic consumption,
  input wire logic install_req,
  input wire logic verify_mode,
  input wire logic seal_open,
  output logic radio_on,
  output logic install_go,
  output logic log_year_dbl,
  output logic log_month_dbl,
  output logic menu_active,
  output msp_pkg::msp_disp_s disp,
  output msp_pkg::msp_cfg_s cfg
);
  // bus address phase capture; zero wait states, always OKAY
  logic wr_q, rd_sel;
  logic [7:0] wa_q;
  logic [31:0] rdata_q;
  wire logic acc = hsel & htrans[1] & hready;
  wire logic wr_ctrl = wr_q & (wa_q == `MSP_A_CTRL);
  wire logic wr_cfg = wr_q & (wa_q == `MSP_A_CFG);
  wire logic wr_dates = wr_q & (wa_q == `MSP_A_DATES);
  wire logic wr_unit = wr_q & (wa_q == `MSP_A_UNIT);
  wire logic wr_addr = wr_q & (wa_q == `MSP_A_ADDR);
  wire logic wr_limit = wr_q & (wa_q == `MSP_A_LIMIT);
  wire logic wr_ofs = wr_q & (wa_q == `MSP_A_OFS);
  wire logic wr_stat = wr_q & (wa_q == `MSP_A_STAT);
  assign rd_sel = acc & ~hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= acc & hwrite;
      wa_q <= {haddr[7:2], 2'b00};
    end
  end

  // key pin synchroniser; a level change counts once stages two and three agree
  logic [2:0] ksync_q;
  logic key_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ksync_q <= 3'b000;
      key_q <= 1'b0;
    end else begin
      ksync_q <= {ksync_q[1:0], key_pin};
      if (ksync_q[1] == ksync_q[2])
        key_q <= ksync_q[2];
    end
  end
  logic key_d1_q;
  wire logic key_press = key_q & ~key_d1_q;
  wire logic key_rel = ~key_q & key_d1_q;

  // one second tick, restarted at every key edge so holds are timed from the press
  logic [31:0] tick_cnt_q;
  wire logic tick = (tick_cnt_q == TICK_CYC - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      key_d1_q <= 1'b0;
    end else begin
      key_d1_q <= key_q;
      if (key_press | key_rel | tick)
        tick_cnt_q <= 32'h0000_0000;
      else
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // configuration and parameter storage
  logic [3:0] mtype_q;
  logic ofs_en_q, hour_en_q, wired_q, outlet_q;
  logic [15:0] hours_pre_q, hours_q;
  logic [11:0] hsec_q;
  logic [15:0] year2_q;
  logic [7:0] month2_q;
  msp_pkg::msp_pair_s unit_q, unit_pend_q;
  logic pend_q;
  logic [7:0] addr_q;
  logic [19:0] limit_q;
  logic ofs_neg_q;
  logic [7:0] ofs_q;
  logic locked_q, transport_q, refused_q;
  logic [3:0] item_q;
  logic editing_q;
  logic [2:0] focus_q;
  logic [3:0] hold_q;
  logic [7:0] idle_q;
  msp_pkg::msp_radio_e radio_q;

  // pair check against the factory table, one comparator per entry
  logic [6:0] pair_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pair
      assign pair_hit[gi] = (UNIT_TABLE[gi] == msp_pkg::msp_pair_s'({hwdata[3:0], hwdata[27:16]}));
    end
  endgenerate
  wire logic pair_ok = |pair_hit;

  // derived conditions
  wire logic is_hc = (mtype_q == `MSP_TYPE_HC);
  wire logic hc_off_item = (item_q == `MSP_ITEM_HC) & ~is_hc;
  wire logic ofs_off_item = (item_q == `MSP_ITEM_OFS) & ~ofs_en_q;
  wire logic off_shown = menu_active & (hc_off_item | ofs_off_item);
  wire logic on_lock = menu_active & (item_q == `MSP_ITEM_LOCK);
  wire logic lock_done = on_lock & key_q & tick & (hold_q == `MSP_LOCK_S - 1);
  wire logic idle_out = menu_active & ~key_q & tick & (idle_q == IDLE_S - 1);
  wire logic trst = wr_ctrl & hwdata[`MSP_CTRL_TRST];
  wire logic enter = wr_ctrl & hwdata[`MSP_CTRL_ENTER] & (~locked_q | seal_open);
  wire logic leave = lock_done | idle_out;
  wire logic edit_ok = is_hc ? (item_q == `MSP_ITEM_HC) : ((item_q == `MSP_ITEM_OFS) & ofs_en_q);
  wire logic can_edit = menu_active & ~editing_q & (hold_q != 4'h0) & key_rel & edit_ok;
  wire logic short_rel = key_rel & (hold_q == 4'h0);
  wire logic long_rel = key_rel & (hold_q != 4'h0);
  wire logic hc_edit = editing_q & (item_q == `MSP_ITEM_HC);
  wire logic ofs_edit = editing_q & (item_q == `MSP_ITEM_OFS);
  wire logic [2:0] last_focus = hc_edit ? 3'h4 : 3'h2;
  wire logic edit_end = editing_q & long_rel & (focus_q == last_focus);
  wire logic hour_hit = hour_en_q & (hours_q == hours_pre_q);

  // bcd digit increment wrapping 9 to 0
  function automatic logic [3:0] msp_inc(input logic [3:0] d);
    msp_inc = (d == 4'h9) ? 4'h0 : d + 4'h1;
  endfunction : msp_inc

  // limit forced to the disabled value when outside the active range
  function automatic logic [19:0] msp_clamp(input logic [19:0] v);
    msp_clamp = (v < `MSP_LIMIT_MIN || v > `MSP_LIMIT_MAX) ? `MSP_LIMIT_OFF : v;
  endfunction : msp_clamp

  // hold and idle second counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q <= 4'h0;
      idle_q <= 8'h00;
    end else begin
      if (key_press | ~key_q)
        hold_q <= 4'h0;
      else if (tick && hold_q != 4'hF)
        hold_q <= hold_q + 4'h1;
      if (key_press | ~menu_active)
        idle_q <= 8'h00;
      else if (tick & ~key_q)
        idle_q <= idle_q + 8'h01;
    end
  end

  // menu navigation and in-place digit editing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      menu_active <= 1'b0;
      item_q <= `MSP_ITEM_FIRST;
      editing_q <= 1'b0;
      focus_q <= 3'h0;
    end else if (trst | leave) begin
      menu_active <= 1'b0;
      editing_q <= 1'b0;
      item_q <= `MSP_ITEM_FIRST;
    end else if (enter) begin
      menu_active <= 1'b1;
      item_q <= `MSP_ITEM_FIRST;
    end else if (can_edit) begin
      editing_q <= 1'b1;
      focus_q <= 3'h0;
    end else if (edit_end) begin
      editing_q <= 1'b0;
    end else if (editing_q & long_rel) begin
      focus_q <= focus_q + 3'h1;
    end else if (menu_active & ~editing_q & short_rel) begin
      item_q <= (item_q == `MSP_ITEM_LOCK) ? `MSP_ITEM_FIRST : item_q + 4'h1;
    end
  end

  // configuration bits and target dates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mtype_q <= 4'h0;
      ofs_en_q <= 1'b0;
      hour_en_q <= 1'b0;
      wired_q <= 1'b0;
      outlet_q <= 1'b0;
      hours_pre_q <= 16'h0000;
      year2_q <= `MSP_DATE_OFF;
      month2_q <= `MSP_DAY_OFF;
      addr_q <= 8'h00;
    end else begin
      if (wr_cfg) begin
        mtype_q <= hwdata[3:0];
        ofs_en_q <= hwdata[`MSP_CFG_OFSEN];
        hour_en_q <= hwdata[`MSP_CFG_HOUREN];
        wired_q <= hwdata[`MSP_CFG_WIRED];
        outlet_q <= hwdata[`MSP_CFG_OUTLET];
        hours_pre_q <= hwdata[31:16];
      end
      if (wr_dates) begin
        year2_q <= hwdata[15:0];
        month2_q <= hwdata[23:16];
      end
      if (wr_addr && hwdata[7:0] <= `MSP_ADDR_MAX && hwdata[31:8] == 24'h000000)
        addr_q <= hwdata[7:0];
    end
  end

  // unit/resolution pair: held pending, committed when the menu is left
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_q <= UNIT_TABLE[0];
      unit_pend_q <= UNIT_TABLE[0];
      pend_q <= 1'b0;
    end else if (wr_unit & pair_ok) begin
      unit_pend_q <= msp_pkg::msp_pair_s'({hwdata[3:0], hwdata[27:16]});
      pend_q <= 1'b1;
    end else if (pend_q & (leave | trst)) begin
      unit_q <= unit_pend_q;
      pend_q <= 1'b0;
    end
  end

  // heat/cooling limit and sensor offset, from the bus or the key
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limit_q <= `MSP_LIMIT_OFF;
      ofs_neg_q <= 1'b0;
      ofs_q <= 8'h00;
    end else begin
      if (wr_limit & is_hc)
        limit_q <= msp_clamp(hwdata[19:0]);
      else if (hc_edit & short_rel)
        limit_q[19 - 4 * focus_q -: 4] <= msp_inc(limit_q[19 - 4 * focus_q -: 4]);
      else if (hc_edit & edit_end)
        limit_q <= msp_clamp(limit_q);
      // only decimals are stored, so the integer digit cannot move off zero
      if (wr_ofs && ofs_en_q && hwdata[7:4] <= 4'h9 && hwdata[3:0] <= 4'h9) begin
        ofs_q <= hwdata[7:0];
        ofs_neg_q <= hwdata[`MSP_OFS_SIGN];
      end else if (ofs_edit & short_rel) begin
        if (focus_q == 3'h0)
          ofs_neg_q <= ~ofs_neg_q;
        else if (focus_q == 3'h1)
          ofs_q[7:4] <= msp_inc(ofs_q[7:4]);
        else
          ofs_q[3:0] <= msp_inc(ofs_q[3:0]);
      end
    end
  end

  // production hour counter, running on the one second tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hsec_q <= 12'h000;
      hours_q <= 16'h0000;
    end else if (tick) begin
      if (hsec_q == 12'(HOUR_S - 1)) begin
        hsec_q <= 12'h000;
        if (hour_en_q && hours_q != 16'hFFFF)
          hours_q <= hours_q + 16'h0001;
      end else begin
        hsec_q <= hsec_q + 12'h001;
      end
    end
  end

  // transport state, lock and radio state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_q <= msp_pkg::RADIO_SUSP;
      transport_q <= 1'b1;
      locked_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (install_req & (radio_q == msp_pkg::RADIO_PERM_OFF))
        refused_q <= 1'b1;
      else if (wr_stat & hwdata[`MSP_STAT_REFUSED])
        refused_q <= 1'b0;
      if (trst) begin
        transport_q <= 1'b1;
        locked_q <= 1'b0;
      end else if (lock_done) begin
        locked_q <= 1'b1;
        transport_q <= 1'b0;
      end else if (first_integ) begin
        transport_q <= 1'b0;
      end
      if (trst) begin
        radio_q <= msp_pkg::RADIO_SUSP;
      end else if (wr_ctrl & hwdata[`MSP_CTRL_RSTB]) begin
        case (hwdata[`MSP_CTRL_RCMD +: 2])
          2'h0: radio_q <= msp_pkg::RADIO_PERM_OFF;
          2'h1: radio_q <= msp_pkg::RADIO_SUSP;
          default: radio_q <= msp_pkg::RADIO_ON;
        endcase
      end else begin
        case (radio_q)
          msp_pkg::RADIO_SUSP: begin
            if (first_integ & transport_q)
              radio_q <= msp_pkg::RADIO_ON;
            else if (~verify_mode & (consumption | hour_hit))
              radio_q <= msp_pkg::RADIO_ON;
          end
          msp_pkg::RADIO_PERM_OFF: radio_q <= msp_pkg::RADIO_PERM_OFF;
          default: radio_q <= radio_q;
        endcase
      end
    end
  end

  // registered outputs: radio, install request pass-on, logging doubles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_on <= 1'b0;
      install_go <= 1'b0;
      log_year_dbl <= 1'b0;
      log_month_dbl <= 1'b0;
    end else begin
      radio_on <= (radio_q == msp_pkg::RADIO_ON) & ~wired_q;
      install_go <= install_req & (radio_q != msp_pkg::RADIO_PERM_OFF);
      log_year_dbl <= (year2_q != `MSP_DATE_OFF);
      log_month_dbl <= (month2_q != `MSP_DAY_OFF);
    end
  end

  // display fields are combinational views of registered state
  always_comb begin
    disp.item = item_q;
    disp.focus = focus_q;
    disp.editing = editing_q;
    disp.frame = key_q & (off_shown | on_lock);
    disp.frame_len = on_lock & key_q ? hold_q[2:0] : 3'h0;
    disp.off_ind = off_shown;
    disp.no_radio_ind = menu_active & wired_q & (item_q == `MSP_ITEM_RADIO);
    disp.flow_outlet = outlet_q;
    disp.radio_sym = wired_q ? 2'b00 : (radio_q == msp_pkg::RADIO_ON) ? 2'b11 :
                     (radio_q == msp_pkg::RADIO_SUSP) ? 2'b01 : 2'b10;
    cfg.flow_outlet = outlet_q;
    cfg.unit_res = unit_q;
    cfg.bus_addr = addr_q;
    cfg.heat_cool_limit = limit_q;
    cfg.heat_cool_active = is_hc & (limit_q != `MSP_LIMIT_OFF);
    cfg.ofs_neg = ofs_neg_q & ofs_en_q;
    cfg.ofs_dec = ofs_en_q ? ofs_q : 8'h00;
  end

  // read data registered during the address phase
  wire logic [31:0] stat_word = {13'h0000, focus_q, item_q, hold_q, refused_q,
    radio_q == msp_pkg::RADIO_ON, radio_q == msp_pkg::RADIO_SUSP,
    radio_q == msp_pkg::RADIO_PERM_OFF, editing_q, transport_q, locked_q, menu_active};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_sel) begin
      case ({haddr[7:2], 2'b00})
        `MSP_A_CFG: rdata_q <= {hours_pre_q, 8'h00, outlet_q, wired_q, hour_en_q, ofs_en_q, mtype_q};
        `MSP_A_DATES: rdata_q <= {8'h00, month2_q, year2_q};
        `MSP_A_UNIT: rdata_q <= {pend_q, 3'h0, unit_q.res, 12'h000, unit_q.unit};
        `MSP_A_ADDR: rdata_q <= {24'h000000, addr_q};
        `MSP_A_LIMIT: rdata_q <= {12'h000, limit_q};
        `MSP_A_OFS: rdata_q <= {23'h000000, ofs_neg_q, ofs_q};
        `MSP_A_STAT: rdata_q <= stat_word;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
endmodule : msp_setup
`default_nettype wire

// file: tb/msp_setup_properties.sv
// port assertions of the meter setup block
`timescale 1ns/1ps
`default_nettype none
module msp_setup_props #(
  parameter msp_pkg::msp_table_t UNIT_TABLE = msp_pkg::UNIT_TABLE
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic first_integ,
  input wire logic consumption,
  input wire logic install_req,
  input wire logic verify_mode,
  input wire logic radio_on,
  input wire logic install_go,
  input wire msp_pkg::msp_disp_s disp,
  input wire msp_pkg::msp_cfg_s cfg
);
  logic pair_ok;
  wire logic bus_take = hsel && htrans[1] && hready;
  // a bus write lands two edges after its address phase, so state changes are traced back that far
  always_comb begin
    pair_ok = 1'b0;
    for (int i = 0; i < 7; i++) pair_ok = pair_ok | (UNIT_TABLE[i] == cfg.unit_res);
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_install_refused: assert property (install_req && disp.radio_sym == 2'b10 |=> !install_go)
    else $error("install accepted while radio permanently off");
  a_install_taken: assert property (install_req && disp.radio_sym[0] |=> install_go)
    else $error("install request not passed on");
  a_limit_clamp: assert property (cfg.heat_cool_limit == 20'h25000 ||
    (cfg.heat_cool_limit >= 20'h00200 && cfg.heat_cool_limit <= 20'h18000))
    else $error("limit outside active range and not disabled");
  a_addr_max: assert property (cfg.bus_addr <= 8'hFA)
    else $error("primary address above 250");
  a_ofs_digits: assert property (cfg.ofs_dec[7:4] <= 4'h9 && cfg.ofs_dec[3:0] <= 4'h9)
    else $error("offset decimal not a digit");
  a_pair_table: assert property (pair_ok)
    else $error("unit and resolution pair not in table");
  a_perm_kept: assert property ($past(disp.radio_sym) == 2'b10 && disp.radio_sym != 2'b10 |->
    $past(bus_take && hwrite, 2))
    else $error("permanent off left without a command");
  a_verify_hold: assert property (verify_mode && consumption && !first_integ &&
    disp.radio_sym == 2'b01 && !$past(bus_take) |=> disp.radio_sym == 2'b01)
    else $error("radio switched on in verification mode");
  a_radio_sym: assert property (radio_on |-> disp.radio_sym == 2'b11 || $past(disp.radio_sym) == 2'b11)
    else $error("radio on without the on state");
endmodule : msp_setup_props
bind msp_setup msp_setup_props #(.UNIT_TABLE(UNIT_TABLE)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .first_integ(first_integ), .consumption(consumption), .install_req(install_req),
  .verify_mode(verify_mode), .radio_on(radio_on), .install_go(install_go), .disp(disp), .cfg(cfg));
`default_nettype wire

// file: tb/msp_tech_model.sv
// technician model working the single front key
`timescale 1ns/1ps
`default_nettype none
module msp_tech_model (
  input wire logic hclk,
  output logic key_pin
);
  // key released reads low; holds are whole cycles after a rising edge
  initial key_pin = 1'b0;
  task automatic press(input int unsigned cyc);
    @(posedge hclk);
    key_pin <= 1'b1;
    repeat (cyc) @(posedge hclk);
    key_pin <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : press
endmodule : msp_tech_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the meter setup block
`timescale 1ns/1ps
`default_nettype none
`include "msp_regs.svh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] ev = 3'h0;
  logic verify_mode = 1'b0;
  logic seal_open = 1'b0;
  logic hreadyout, hresp, key_pin, radio_on, install_go, log_year_dbl, log_month_dbl, menu_active;
  logic [31:0] hrdata;
  msp_pkg::msp_disp_s disp;
  msp_pkg::msp_cfg_s cfg;
  int unsigned err_total = 0;
  int unsigned checks_done = 0;
  int unsigned cyc = 0;
  logic [19:0] corner [4] = '{20'h00200, 20'h18000, 20'h00199, 20'h18001};

  // 200 MHz clock
  always #2.5 hclk = ~hclk;

  msp_setup #(.TICK_CYC(10), .IDLE_S(3), .HOUR_S(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .key_pin(key_pin), .first_integ(ev[0]), .consumption(ev[1]), .install_req(ev[2]),
    .verify_mode(verify_mode), .seal_open(seal_open), .radio_on(radio_on), .install_go(install_go),
    .log_year_dbl(log_year_dbl), .log_month_dbl(log_month_dbl), .menu_active(menu_active),
    .disp(disp), .cfg(cfg));
  msp_tech_model tech (.hclk(hclk), .key_pin(key_pin));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // hang guard, far above the fewer than one thousand cycles the sequence needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer; the master waits for hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // write, then let the register and any state it drives settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    repeat (2) @(negedge hclk);
  endtask : wr

  task automatic fire(input logic [2:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= 3'h0;
    @(negedge hclk);
  endtask : fire

  function automatic logic [19:0] bcd5();
    logic [19:0] v;
    for (int i = 0; i < 5; i++) v[4*i+:4] = 4'($urandom % 10);
    return v;
  endfunction : bcd5

  function automatic logic [19:0] lim_exp(input logic [19:0] v);
    return (v >= 20'h00200 && v <= 20'h18000) ? v : 20'h25000;
  endfunction : lim_exp

  initial begin
    logic [31:0] v;
    logic [19:0] lim;
    logic [7:0] ad;
    logic [7:0] ad_q;
    int unsigned n;
    v = $urandom(32'h57BD);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    // factory state after reset
    chk(32'({disp.radio_sym, radio_on, log_year_dbl, log_month_dbl}), 32'h8);
    chk(32'(cfg.unit_res), 32'h0000_2419);
    chk({12'h000, cfg.heat_cool_limit}, 32'h0002_5000);
    wr(`MSP_A_DATES, 32'h0000_1231);
    chk(32'({log_year_dbl, log_month_dbl}), 32'h2);
    wr(`MSP_A_DATES, 32'h0015_0000);
    chk(32'({log_year_dbl, log_month_dbl}), 32'h1);
    bus(1'b0, 8'h40, 32'h0, v);
    chk(v, 32'h0);
    chk(32'({hreadyout, hresp}), 32'h2);
    wr(`MSP_A_CFG, 32'h0000_0082);
    chk(32'({cfg.flow_outlet, disp.flow_outlet}), 32'h3);
    wr(`MSP_A_LIMIT, 32'h0000_1234);
    chk(32'(cfg.heat_cool_limit), 32'h0002_5000);
    wr(`MSP_A_CFG, 32'h0000_0006);
    // limit corners then random digits, and primary addresses 250 and 251 then random ones
    for (int i = 0; i < 16; i++) begin
      lim = (i < 4) ? corner[i] : bcd5();
      wr(`MSP_A_LIMIT, {12'h0, lim});
      chk(32'({cfg.heat_cool_active, cfg.heat_cool_limit}), {11'h0, lim_exp(lim) != 20'h25000, lim_exp(lim)});
      ad = (i < 2) ? 8'hFA + 8'(i) : 8'($urandom);
      if (ad <= 8'hFA) ad_q = ad;
      wr(`MSP_A_ADDR, {24'h0, ad});
      chk(32'(cfg.bus_addr), {24'h0, ad_q});
    end
    wr(`MSP_A_OFS, 32'h0000_0137);
    chk(32'({cfg.ofs_neg, cfg.ofs_dec}), 32'h0);
    wr(`MSP_A_CFG, 32'h0000_0016);
    wr(`MSP_A_OFS, 32'h0000_0137);
    wr(`MSP_A_OFS, 32'h0000_005A);
    chk(32'({cfg.ofs_neg, cfg.ofs_dec}), 32'h137);
    // pending unit pair, committed when the idle timeout closes the menu
    wr(`MSP_A_CTRL, 32'h1);
    wr(`MSP_A_UNIT, 32'h0407_0004);
    bus(1'b0, `MSP_A_UNIT, 32'h0, v);
    chk(v, 32'h0419_0002);
    wr(`MSP_A_UNIT, 32'h0455_0003);
    bus(1'b0, `MSP_A_UNIT, 32'h0, v);
    chk({v[31:16], 16'(cfg.unit_res)}, 32'h8419_2419);
    n = 0;
    while (menu_active !== 1'b0 && n < 40) begin
      @(negedge hclk);
      n++;
    end
    chk(32'({menu_active, cfg.unit_res}), 32'h3455);
    // lock item: a four second hold cancels, the full hold locks and commits
    wr(`MSP_A_CTRL, 32'h1);
    wr(`MSP_A_UNIT, 32'h0419_0004);
    repeat (13) tech.press(4);
    chk(32'(disp.item), 32'hE);
    // the frame grows with whole seconds of hold while the key is down
    fork
      tech.press(45);
      begin
        repeat (30) @(negedge hclk);
        chk(32'({disp.frame, disp.frame_len, disp.off_ind}), 32'h14);
      end
    join
    bus(1'b0, `MSP_A_STAT, 32'h0, v);
    chk(32'({menu_active, v[1]}), 32'h2);
    tech.press(70);
    bus(1'b0, `MSP_A_STAT, 32'h0, v);
    chk(32'({menu_active, v[1], cfg.unit_res}), 32'h1_4419);
    wr(`MSP_A_CTRL, 32'h1);
    chk(32'(menu_active), 32'h0);
    @(posedge hclk);
    seal_open <= 1'b1;
    wr(`MSP_A_CTRL, 32'h1);
    chk(32'(menu_active), 32'h1);
    // key edit of the limit: a long press on item 11 starts it, a short press steps the first digit
    wr(`MSP_A_LIMIT, 32'h0000_0200);
    repeat (10) tech.press(4);
    tech.press(15);
    tech.press(4);
    @(negedge hclk);
    chk(32'({disp.item, disp.editing, disp.focus, cfg.heat_cool_limit}), 32'h0B81_0200);
    // radio states and what may move between them
    wr(`MSP_A_CTRL, 32'h4);
    fire(3'h3);
    fire(3'h4);
    chk(32'({install_go, disp.radio_sym}), 32'h2);
    wr(`MSP_A_CTRL, 32'h14);
    fire(3'h4);
    chk(32'({install_go, disp.radio_sym}), 32'h5);
    // verification mode on in the first pass, then drawn at random; only outside it does consumption switch the radio on
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      verify_mode <= (i == 0) ? 1'b1 : 1'($urandom);
      fire(3'h2);
      chk(32'(disp.radio_sym), verify_mode ? 32'h1 : 32'h3);
      wr(`MSP_A_CTRL, 32'h14);
    end
    @(posedge hclk);
    verify_mode <= 1'b0;
    fire(3'h2);
    @(negedge hclk);
    chk(32'({radio_on, disp.radio_sym}), 32'h7);
    wr(`MSP_A_CTRL, 32'h2);
    chk(32'({radio_on, disp.radio_sym}), 32'h1);
    fire(3'h1);
    @(negedge hclk);
    chk(32'({radio_on, disp.radio_sym}), 32'h7);
    wr(`MSP_A_CTRL, 32'h14);
    // production hour timer: a preset of one hour switches a suspended radio on
    wr(`MSP_A_CFG, 32'h0001_0036);
    repeat (50) @(negedge hclk);
    chk(32'({radio_on, disp.radio_sym}), 32'h7);
    wr(`MSP_A_CTRL, 32'h14);
    wr(`MSP_A_CTRL, 32'h24);
    chk(32'({radio_on, disp.radio_sym}), 32'h7);
    wr(`MSP_A_CFG, 32'h0000_0046);
    chk(32'({radio_on, disp.radio_sym}), 32'h0);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
